//--- bench/mux_sva.sv
// Purpose: Port checks for the mux
// Assumes: Roles change in reset only
// Notes:   Packet clock half period 4
`timescale 1ns/1ps
module mux_sva (
   input wire       sys_clk,
   input wire       rst_n,
   input wire       operating_mode,
   input wire [1:0] port_pins_out,
   input wire       tx_packet_byte_clock,
   input wire       add_byte_valid,
   input wire       packet_byte_valid
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_a; add_byte_valid |=> !add_byte_valid; endproperty
   a_a: assert property (p_a) else $error("add");
   property p_b; packet_byte_valid |-> $rose(tx_packet_byte_clock); endproperty
   a_b: assert property (p_b) else $error("pkt");
   property p_c; $rose(tx_packet_byte_clock) |-> tx_packet_byte_clock[*4] ##1
      !tx_packet_byte_clock; endproperty
   a_c: assert property (p_c) else $error("hi");
   property p_d; $fell(tx_packet_byte_clock) |-> !tx_packet_byte_clock[*4]; endproperty
   a_d: assert property (p_d) else $error("lo");
   property p_e; packet_byte_valid |-> !operating_mode; endproperty
   a_e: assert property (p_e) else $error("role");
   property p_f; |port_pins_out |-> operating_mode; endproperty
   a_f: assert property (p_f) else $error("ind");
   property p_g; $rose(port_pins_out[1]) |-> port_pins_out[1][*8] ##1 !port_pins_out[1];
      endproperty
   a_g: assert property (p_g) else $error("fe");
   property p_h; $rose(port_pins_out[0]) |-> port_pins_out[0][*8] ##1 !port_pins_out[0];
      endproperty
   a_h: assert property (p_h) else $error("oh");
endmodule // mux_sva
bind tx_ch0_input_port_mux mux_sva chk (.sys_clk, .rst_n, .operating_mode, .port_pins_out,
   .tx_packet_byte_clock, .add_byte_valid, .packet_byte_valid);

//--- bench/payload_source.sv
// Purpose: Equipment feeding serial payload
// Assumes: Bit clock 160 ns, still unless run
// Notes:   Resends a bit put in an overhead slot
`timescale 1ns/1ps
module payload_source (
   input  wire run,
   input  wire oh_ind,
   output reg  clk,
   output reg  dat
);
   reg [7:0] seq = 8'h00;
   initial begin
      {clk, dat} = 2'h0;
      #7;
      forever #80 clk = run & ~clk;
   end
   always @(posedge clk) if (!oh_ind) seq <= seq + 8'h01;
   always @(negedge clk) dat <= seq[1];
endmodule // payload_source

//--- bench/tb_tx_ch0_input_port_mux.sv
// Purpose: Bench for the port mux
// Assumes: Roles set in reset
// Notes:   Short frame counts
`timescale 1ns/1ps
module tb_tx_ch0_input_port_mux;
   reg        sys_clk = 1'b0, rst_n = 1'b0, tx_add_bus_clock = 1'b1, run = 1'b0;
   reg        add_bus_enable = 1'b0, operating_mode = 1'b0;
   reg  [7:0] pd = 8'h00;
   wire [1:0] port_pins_out, port_pins_oe;
   wire [7:0] add_byte, packet_byte, port_pins_in;
   wire       tx_payload_input_clock, tx_packet_byte_clock, sd, payload_bit;
   wire       add_byte_valid, packet_byte_valid, payload_bit_valid;
   integer    miscompares = 0, total_checks = 0, k, fe, oh, v;
   wire [1:0] drv = port_pins_oe & port_pins_out | ~port_pins_oe & pd[5:4];
   assign port_pins_in = {pd[7], (operating_mode & ~add_bus_enable) ? sd : pd[6], drv, pd[3:0]};
   always #10 sys_clk = ~sys_clk;
   tx_ch0_input_port_mux #(.FRAME_BITS(16), .OH_PERIOD(5)) dut (.sys_clk, .rst_n,
      .add_bus_enable, .operating_mode, .port_pins_in, .port_pins_out, .port_pins_oe,
      .tx_add_bus_clock, .tx_payload_input_clock, .tx_packet_byte_clock, .add_byte,
      .add_byte_valid, .packet_byte, .packet_byte_valid, .payload_bit, .payload_bit_valid);
   payload_source src (.run, .oh_ind(port_pins_in[4]), .clk(tx_payload_input_clock), .dat(sd));
   task cmp(input [7:0] s, e);
      begin
         total_checks = total_checks + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
         end
      end
   endtask
   task role(input a, m, input [7:0] p);
      begin
         @(posedge sys_clk) #1 {rst_n, add_bus_enable, operating_mode, pd} = {1'b0, a, m, p};
         repeat (12) @(posedge sys_clk);
         #1 rst_n = 1'b1;
         #160 tx_add_bus_clock = 1'b0;
         wait_valid(a);
      end
   endtask
   task wait_valid(input a);
      begin
         k = 0;
         do @(posedge sys_clk) #1 k = k + 1;
         while ((a ? add_byte_valid : packet_byte_valid) !== 1'b1 && k < 30);
      end
   endtask
   task t_add;
      begin
         role(1'b1, 1'b0, 8'hA5);
         cmp(add_byte, 8'hA5);
         $display("add test end");
      end
   endtask
   task t_pkt;
      begin
         role(1'b0, 1'b0, 8'h3C);
         cmp(packet_byte, 8'h3C);
         cmp(port_pins_oe, 8'h00);
         pd = 8'h5A;
         wait_valid(1'b0);
         wait_valid(1'b0);
         cmp(packet_byte, 8'h5A);
         $display("packet test end");
      end
   endtask
   task t_frm;
      begin
         role(1'b0, 1'b1, 8'h00);
         cmp(port_pins_oe, 8'h03);
         {fe, oh, v} = 96'h0;
         run = 1'b1;
         fork
            begin
               repeat (49) @(posedge tx_payload_input_clock);
               run = 1'b0;
            end
            repeat (440) begin
               @(posedge sys_clk) #1 fe = fe + port_pins_out[1];
               oh = oh + port_pins_out[0];
               if (payload_bit_valid === 1'b1) begin
                  cmp(payload_bit, v[1]);
                  v = v + 1;
               end
            end
         join
         cmp(fe[7:0], 8'h18);
         cmp(oh[7:0], 8'h48);
         cmp(v[7:0], 8'h28);
         $display("framer test end");
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      t_add;
      t_pkt;
      t_frm;
      give_verdict;
   end
   initial begin
      #40000 miscompares = miscompares + 1;
      give_verdict;
   end
endmodule // tb_tx_ch0_input_port_mux

//--- design/edge_sync.v
// Purpose: Three-stage synchroniser with rise and fall detection
// Assumes: Input is asynchronous to sys_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
module edge_sync (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire din,
   output reg  level,
   output reg  rise,
   output reg  fall
);
   reg s1;
   reg s2;
   reg s3;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         rise <= 1'b0;
         fall <= 1'b0;
         if (s2 == s3 && s3 != level) begin
            level <= s3;
            rise  <= s3;
            fall  <= ~s3;
         end
      end
   end
endmodule // edge_sync

//--- design/tx_ch0_input_port_mux.v
// Purpose: Channel-0 transmit input port: shared pins in add-bus, packet or framer role
// Assumes: All link clocks and pins are slow next to sys_clk and pass through edge_sync
// Notes:   Shared pins 4 and 5 are two-way; the mux drives them only in framer mode
//          Every pin and link clock passes edge_sync, about four cycles of delay
//          Packet clock period is two times PKT_CLK_HALF system clock cycles
//          Overhead indicator stands one payload period; the next sampled bit is dropped
//          Frame and overhead counts restart whenever the framer role is left
// Functional notes
// [R1] Role of shared pins depends on whether the add bus is enabled.
// [R2] Add bus off: operating mode picks packet input or framer indicator role.
// [R3] Add bus on: pins form one byte, latched on add clock falling edge.
// [R4] Packet mode: shared pin five is bit five of the packet byte.
// [R5] Packet mode: device drives byte-rate packet clock toward the equipment.
// [R6] Packet mode: all eight bits captured on rising edge of packet clock.
// [R7] Framer mode: frame-end pulse high one payload clock on the frame's last bit.
// [R8] Framer mode: overhead indicator warns that next payload slot is ignored.
// [R9] Equipment seeing indicator high withholds the next payload bit.
// [R10] Framer mode: serial payload sampled on rising payload input clock edge.
// [R11] Indicators generated in the payload clock domain, ready for next bit.
`timescale 1ns/1ps
`include "tx_port_map.vh"
module tx_ch0_input_port_mux #(
   parameter FRAME_BITS   = `FRAME_BITS_DEF,
   parameter OH_PERIOD    = `OH_PERIOD_DEF,
   parameter PKT_CLK_HALF = `PKT_CLK_HALF_DEF
) (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       add_bus_enable,
   input  wire       operating_mode,
   input  wire [7:0] port_pins_in,
   output reg  [1:0] port_pins_out,
   output reg  [1:0] port_pins_oe,
   input  wire       tx_add_bus_clock,
   input  wire       tx_payload_input_clock,
   output reg        tx_packet_byte_clock,
   output reg  [7:0] add_byte,
   output reg        add_byte_valid,
   output reg  [7:0] packet_byte,
   output reg        packet_byte_valid,
   output reg        payload_bit,
   output reg        payload_bit_valid
);
   // Terminal counts, cut to counter width on purpose
   localparam [31:0] FRAME_LAST_W = FRAME_BITS - 1;
   localparam [31:0] OH_LAST_W    = OH_PERIOD - 1;
   localparam [31:0] HALF_LAST_W  = PKT_CLK_HALF - 1;
   localparam [12:0] FRAME_LAST   = FRAME_LAST_W[12:0];
   localparam [7:0]  OH_LAST      = OH_LAST_W[7:0];
   localparam [3:0]  HALF_LAST    = HALF_LAST_W[3:0];

   wire        add_fall;
   wire        pay_rise;
   wire [7:0]  pins_sync;
   wire [7:0]  tx_packet_byte_input;
   wire        tx_payload_serial_input;
   wire        tx_add_bus_data_bit4;
   wire        tx_add_bus_data_bit5;
   wire        frame_last_slot;
   wire        oh_last_slot;
   wire        half_done;
   wire        pkt_capture;
   wire        add_take;
   wire        framer_role;
   wire        packet_role;

   reg  [3:0]  half_cnt;
   reg  [12:0] bit_cnt;
   reg  [7:0]  oh_cnt;
   reg         oh_pending;
   reg  [12:0] next_bit_cnt;
   reg  [7:0]  next_oh_cnt;
   reg         next_oh_pending;
   reg         next_payload_bit;
   reg         next_payload_bit_valid;
   reg  [1:0]  next_pins_out;

   // Role decode: add bus wins, then operating mode
   assign framer_role = !add_bus_enable && operating_mode == `MODE_FRAMER; // see [R1] [R2]
   assign packet_role = !add_bus_enable && operating_mode == `MODE_PACKET; // see [R2]

   // Synced pins under their per-role names
   assign tx_packet_byte_input    = pins_sync; // see [R4]
   assign tx_add_bus_data_bit4    = pins_sync[`PIN_BIT4];
   assign tx_add_bus_data_bit5    = pins_sync[`PIN_BIT5];
   assign tx_payload_serial_input = pins_sync[`PIN_BIT6];

   assign add_take        = add_bus_enable && add_fall;
   assign half_done       = (half_cnt == HALF_LAST);
   assign pkt_capture     = packet_role && half_done && !tx_packet_byte_clock;
   assign frame_last_slot = (bit_cnt == FRAME_LAST);
   assign oh_last_slot    = (oh_cnt == OH_LAST);

   // Edge finders for the two link clocks
   edge_sync u_add_clk (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .din     (tx_add_bus_clock),
      .level   (),
      .rise    (),
      .fall    (add_fall)
   );

   edge_sync u_pay_clk (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .din     (tx_payload_input_clock),
      .level   (),
      .rise    (pay_rise),
      .fall    ()
   );

   // One synchroniser per shared pin
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_pin
         edge_sync u_pin (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .din     (port_pins_in[i]),
            .level   (pins_sync[i]),
            .rise    (),
            .fall    ()
         );
      end
   endgenerate

   // Add bus byte
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         add_byte       <= `BYTE_RESET_VAL;
         add_byte_valid <= 1'b0;
      end else begin
         add_byte_valid <= 1'b0;
         if (add_take) begin
            add_byte       <= {pins_sync[7:6], tx_add_bus_data_bit5, tx_add_bus_data_bit4,
                               pins_sync[3:0]}; // see [R3]
            add_byte_valid <= 1'b1;
         end
      end
   end

   // Packet clock generator and byte capture
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt             <= 4'h0;
         tx_packet_byte_clock <= 1'b0;
         packet_byte          <= `BYTE_RESET_VAL;
         packet_byte_valid    <= 1'b0;
      end else begin
         packet_byte_valid <= 1'b0;
         if (!packet_role) begin
            half_cnt             <= 4'h0;
            tx_packet_byte_clock <= 1'b0;
         end else if (half_done) begin
            half_cnt             <= 4'h0;
            tx_packet_byte_clock <= ~tx_packet_byte_clock; // see [R5]
         end else begin
            half_cnt <= half_cnt + 4'h1;
         end
         // Capture on the clock's low to high toggle
         if (pkt_capture) begin
            packet_byte       <= tx_packet_byte_input; // see [R4] [R6]
            packet_byte_valid <= 1'b1;
         end
      end
   end

   // Serial payload and frame/overhead indicators, paced by payload clock
   always @* begin
      next_bit_cnt           = bit_cnt;
      next_oh_cnt            = oh_cnt;
      next_oh_pending        = oh_pending;
      next_payload_bit       = payload_bit;
      next_payload_bit_valid = 1'b0;
      next_pins_out          = port_pins_out;
      if (!framer_role) begin
         next_bit_cnt    = 13'h0000;
         next_oh_cnt     = 8'h00;
         next_oh_pending = 1'b0;
         next_pins_out   = 2'h0;
      end else if (pay_rise) begin
         // Slot flagged one period earlier carries no payload
         if (!oh_pending) begin
            next_payload_bit       = tx_payload_serial_input; // see [R10] [R9]
            next_payload_bit_valid = 1'b1;
         end
         if (frame_last_slot) begin
            next_bit_cnt = 13'h0000;
         end else begin
            next_bit_cnt = bit_cnt + 13'h0001;
         end
         if (oh_last_slot) begin
            next_oh_cnt = 8'h00;
         end else begin
            next_oh_cnt = oh_cnt + 8'h01;
         end
         next_oh_pending  = oh_last_slot;
         next_pins_out[1] = frame_last_slot; // see [R7] [R11]
         next_pins_out[0] = oh_last_slot; // see [R8] [R11]
      end
   end

   // Register the payload slot state
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt           <= 13'h0000;
         oh_cnt            <= 8'h00;
         oh_pending        <= 1'b0;
         payload_bit       <= 1'b0;
         payload_bit_valid <= 1'b0;
         port_pins_out     <= 2'h0;
         port_pins_oe      <= 2'h0;
      end else begin
         bit_cnt           <= next_bit_cnt;
         oh_cnt            <= next_oh_cnt;
         oh_pending        <= next_oh_pending;
         payload_bit       <= next_payload_bit;
         payload_bit_valid <= next_payload_bit_valid;
         port_pins_out     <= next_pins_out;
         port_pins_oe      <= {framer_role, framer_role}; // see [R1]
      end
   end
endmodule // tx_ch0_input_port_mux

//--- pkg/tx_port_map.vh
// Purpose: Constants for the channel-0 transmit input port mux
// Assumes: 50 MHz system clock
// Notes:   Mode codes, pin positions, default frame and pacing counts
`ifndef TX_PORT_MAP_VH
`define TX_PORT_MAP_VH

`define MODE_PACKET        1'b0
`define MODE_FRAMER        1'b1
`define PIN_BIT4           4
`define PIN_BIT5           5
`define PIN_BIT6           6
`define FRAME_BITS_DEF     4760
`define OH_PERIOD_DEF      85
`define PKT_CLK_HALF_DEF   4
`define BYTE_RESET_VAL     8'h00

`endif
